//--- dv/dac_model.sv
// behavioural converter that holds the last loaded code
`timescale 1ns/10ps
`default_nettype none
module dac_model
  import analog_output_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic [CODE_W-1:0] code,
  input  wire logic              load,
  output logic      [CODE_W-1:0] held_code
);
  // the load strobe is the only cue; a missed pulse shows as a stale level
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      held_code <= CODE_RESET;
    end else if (load) begin
      held_code <= code;
    end
  end
endmodule : dac_model
`default_nettype wire

//--- dv/tb.sv
// self-checking bench for the analog output scaler
`timescale 1ns/10ps
`default_nettype none
module tb;
  import analog_output_pkg::*;
  logic                      clock = 1'b0;
  logic                      reset_n = 1'b0;
  source_t                   source_select = SRC_DISPLAYED;
  logic                      output_mode = MODE_CURRENT;
  logic                      rate_enable = 1'b1;
  logic [CODE_W-1:0]         zero_cal = 16'h1000;
  logic [CODE_W-1:0]         high_cal = 16'hF000;
  logic [VALUE_W-1:0]        span_max = 32'h000003E8;
  logic signed [VALUE_W-1:0] displayed_weight = '0;
  logic signed [VALUE_W-1:0] gross_weight = '0;
  logic signed [VALUE_W-1:0] rate_value = '0;
  logic                      displayed_valid = 1'b0;
  logic                      gross_valid = 1'b0;
  logic                      rate_valid = 1'b0;
  logic                      blank_under = 1'b0;
  logic                      blank_over = 1'b0;
  logic [CODE_W-1:0]         dac_code;
  logic [CODE_W-1:0]         held_code;
  logic                      dac_load;
  logic                      under_clamp;
  logic                      over_clamp;
  logic                      rate_blocked;
  logic                      busy;
  int                        failures = 0;
  int                        comparisons = 0;
  int                        loads = 0;
  int                        runs = 0;

  analog_output_scaler dut (
    .clock(clock), .reset_n(reset_n), .source_select(source_select),
    .output_mode(output_mode), .rate_enable(rate_enable), .zero_cal(zero_cal),
    .high_cal(high_cal), .span_max(span_max), .displayed_weight(displayed_weight),
    .displayed_valid(displayed_valid), .gross_weight(gross_weight),
    .gross_valid(gross_valid), .rate_value(rate_value), .rate_valid(rate_valid),
    .blank_under(blank_under), .blank_over(blank_over), .dac_code(dac_code),
    .dac_load(dac_load), .under_clamp(under_clamp), .over_clamp(over_clamp),
    .rate_blocked(rate_blocked), .busy(busy)
  );

  dac_model far_end (
    .clock(clock), .reset_n(reset_n), .code(dac_code), .load(dac_load),
    .held_code(held_code)
  );

  always #12.5 clock = ~clock;

  always @(posedge clock) begin
    if (dac_load === 1'b1) loads++;
  end

  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task automatic check_code(string what, logic [CODE_W-1:0] exp, logic [CODE_W-1:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check_code

  task automatic check_bit(string what, logic exp, logic got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_count(string what, int exp, int got);
    comparisons++;
    if (got != exp) begin
      failures++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check_count

  // expected code from the calibration points, worked in wide signed math
  function automatic logic [CODE_W-1:0] lin(longint mag);
    return 16'(longint'(zero_cal) + mag * (longint'(high_cal) - longint'(zero_cal))
               / longint'(span_max));
  endfunction : lin

  // every valid pulses at once; unselected sources carry the negated value,
  // so for a nonzero value from a non-absolute source, using the wrong one shows up as a different code
  task automatic send(source_t src, int val, logic bu, logic bo, logic eb, output int lat);
    source_select = src;
    blank_under = bu;
    blank_over = bo;
    displayed_weight = (src == SRC_DISPLAYED || src == SRC_ABS_DISPLAYED) ? val : -val;
    gross_weight = (src == SRC_GROSS) ? val : -val;
    rate_value = (src == SRC_RATE || src == SRC_ABS_RATE) ? val : -val;
    {displayed_valid, gross_valid, rate_valid} = 3'h7;
    @(negedge clock);
    {displayed_valid, gross_valid, rate_valid} = 3'h0;
    lat = 1;
    while (dac_load !== 1'b1 && lat < 120) begin
      if (lat == 10) check_bit("busy", eb, busy);
      @(negedge clock);
      lat++;
    end
  endtask : send

  task automatic run(source_t src, int val, logic bu, logic bo,
                     logic [CODE_W-1:0] ec, logic eu, logic eo);
    int lat;
    runs++;
    send(src, val, bu, bo, 1'b1, lat);
    check_count("latency", 53, lat);
    check_code("dac_code", ec, dac_code);
    check_bit("under_clamp", eu, under_clamp);
    check_bit("over_clamp", eo, over_clamp);
    @(negedge clock);
    check_code("converter level", ec, held_code);
    check_bit("dac_load pulse", 1'b0, dac_load);
  endtask : run

  task automatic refused(source_t src, int val);
    int lat;
    send(src, val, 1'b0, 1'b0, 1'b0, lat);
    check_count("ignored sample", 120, lat);
  endtask : refused

  initial begin
    repeat (8) @(negedge clock);
    reset_n = 1'b1;
    check_code("reset code", CODE_RESET, dac_code);
    for (int s = 0; s < 5; s++) begin
      run(source_t'(s), 0, 1'b0, 1'b0, 16'h1000, 1'b0, 1'b0);
      run(source_t'(s), 500, 1'b0, 1'b0, 16'h8000, 1'b0, 1'b0);
      run(source_t'(s), 1000, 1'b0, 1'b0, 16'hF000, 1'b0, 1'b0);
    end
    output_mode = MODE_VOLTAGE;
    run(SRC_GROSS, 250, 1'b0, 1'b0, lin(250), 1'b0, 1'b0);
    run(SRC_DISPLAYED, 100, 1'b1, 1'b0, CODE_V_FLOOR, 1'b1, 1'b0);
    run(SRC_DISPLAYED, 100, 1'b0, 1'b1, CODE_FULL, 1'b0, 1'b1);
    output_mode = MODE_CURRENT;
    run(SRC_DISPLAYED, 100, 1'b1, 1'b0, CODE_0MA, 1'b1, 1'b0);
    run(SRC_GROSS, -500, 1'b0, 1'b0, CODE_0MA, 1'b1, 1'b0);
    run(SRC_RATE, -1, 1'b0, 1'b0, CODE_0MA, 1'b1, 1'b0);
    run(SRC_GROSS, 100, 1'b0, 1'b1, CODE_24MA, 1'b0, 1'b1);
    run(SRC_RATE, 2000, 1'b0, 1'b0, CODE_24MA, 1'b0, 1'b1);
    run(SRC_ABS_DISPLAYED, -500, 1'b0, 1'b0, 16'h8000, 1'b0, 1'b0);
    run(SRC_ABS_RATE, -1000, 1'b0, 1'b0, 16'hF000, 1'b0, 1'b0);
    run(SRC_RATE, 100, 1'b1, 1'b1, lin(100), 1'b0, 1'b0);
    zero_cal = 16'h2000;
    high_cal = 16'h3000;
    run(SRC_DISPLAYED, 500, 1'b0, 1'b0, 16'h2800, 1'b0, 1'b0);
    run(SRC_DISPLAYED, -100, 1'b0, 1'b0, 16'h1E67, 1'b0, 1'b0);
    zero_cal = 16'hF000;
    high_cal = 16'hFFFF;
    run(SRC_DISPLAYED, 2000, 1'b0, 1'b0, CODE_FULL, 1'b0, 1'b1);
    rate_enable = 1'b0;
    refused(SRC_RATE, 500);
    check_bit("rate_blocked", 1'b1, rate_blocked);
    refused(SRC_ABS_RATE, 500);
    rate_enable = 1'b1;
    refused(source_t'(5), 100);
    repeat (2) @(negedge clock);
    check_bit("rate_blocked cleared", 1'b0, rate_blocked);
    check_code("held code", CODE_FULL, dac_code);
    check_count("load count", runs, loads);
    test_done();
  end

  // 29 loaded samples of some 54 cycles and 3 ignored ones of 120 cycles; ample margin beyond that
  initial begin
    #(25 * 20000);
    failures++;
    $display("BAD watchdog expected end seen hang");
    test_done();
  end
endmodule : tb
`default_nettype wire

//--- src/analog_output_pkg.sv
// constants and types shared by the analog output scaler
// Functional notes
// R1 - Configuration picks one of five sources: displayed, absolute displayed, gross, rate, absolute rate.
// R2 - The converter code is 16 bits wide, giving 65536 levels over the whole output range.
// R3 - One channel only, configured as a 4-20 mA current output or a 0-10 V voltage output.
// R4 - For displayed, gross and rate sources a zero value gives the low end: 0 V or 4 mA.
// R5 - A value at its configured maximum gives the high end: 10 V or 20 mA.
// R6 - Between zero and the maximum the output fraction of span equals the value fraction.
// R7 - Absolute sources drop the sign of negative values so the output rises with magnitude.
// R8 - Calibrated zero and high-limit codes are adjustable and are used in the scaling.
// R9 - A rate or absolute-rate source is used only while the rate function is enabled.
// R10 - Under-zero and over-limit handling depends on both the source and the output type.
// R11 - In current mode an under-zero blank or negative overrange drives about 0 mA until back in range.
// R12 - In current mode an over-limit blank or positive overrange drives about 24 mA until back in range.
// R13 - With the absolute-rate source negative rates are valid and never cause the under-zero clamp.
// R14 - The code is recomputed and loaded on each new sample of the chosen source and held between.
// R15 - The computed code saturates to the 16-bit range and never wraps.
package analog_output_pkg;

  localparam int CODE_W = 16;
  localparam int VALUE_W = 32;
  localparam int PROD_W = 48;

  typedef logic [2:0] source_t;
  localparam source_t SRC_DISPLAYED = 3'h0;
  localparam source_t SRC_ABS_DISPLAYED = 3'h1;
  localparam source_t SRC_GROSS = 3'h2;
  localparam source_t SRC_RATE = 3'h3;
  localparam source_t SRC_ABS_RATE = 3'h4;

  localparam logic MODE_CURRENT = 1'b0;
  localparam logic MODE_VOLTAGE = 1'b1;

  // code values for the clamp levels; tune to the converter's transfer curve
  localparam logic [CODE_W-1:0] CODE_0MA = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_24MA = 16'hFFFF;
  localparam logic [CODE_W-1:0] CODE_V_FLOOR = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_FULL = 16'hFFFF;
  localparam logic [CODE_W-1:0] CODE_RESET = 16'h0000;

  localparam logic [5:0] DIV_STEPS = 6'h30;
  localparam logic [5:0] DIV_LAST = 6'h01;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_DIVIDE = 2'b10,
    ST_LOAD = 2'b11
  } scale_state_e;

endpackage : analog_output_pkg

//--- src/analog_output_scaler.sv
// source selection, linear scaling and clamping for the analog output code
`timescale 1ns/10ps
`default_nettype none
module analog_output_scaler
  import analog_output_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       reset_n,
  input  wire analog_output_pkg::source_t source_select,
  input  wire logic                       output_mode,
  input  wire logic                       rate_enable,
  input  wire logic [CODE_W-1:0]          zero_cal,
  input  wire logic [CODE_W-1:0]          high_cal,
  input  wire logic [VALUE_W-1:0]         span_max,
  input  wire logic signed [VALUE_W-1:0]  displayed_weight,
  input  wire logic                       displayed_valid,
  input  wire logic signed [VALUE_W-1:0]  gross_weight,
  input  wire logic                       gross_valid,
  input  wire logic signed [VALUE_W-1:0]  rate_value,
  input  wire logic                       rate_valid,
  input  wire logic                       blank_under,
  input  wire logic                       blank_over,
  output logic      [CODE_W-1:0]          dac_code,
  output logic                            dac_load,
  output logic                            under_clamp,
  output logic                            over_clamp,
  output logic                            rate_blocked,
  output logic                            busy
);
  import analog_output_pkg::*;

  function automatic logic [VALUE_W-1:0] magnitude(input logic signed [VALUE_W-1:0] v);
    magnitude = v[VALUE_W-1] ? VALUE_W'(-v) : VALUE_W'(v);
  endfunction : magnitude

  function automatic logic is_rate_src(input source_t s);
    is_rate_src = (s == SRC_RATE) || (s == SRC_ABS_RATE);
  endfunction : is_rate_src

  // selected sample
  logic signed [VALUE_W-1:0] sel_value;
  logic                      sel_valid;
  logic                      sel_legal;
  logic                      accept;

  // one-deep pending slot so a sample arriving mid-division is not lost
  logic signed [VALUE_W-1:0] pend_value;
  logic signed [VALUE_W-1:0] next_pend_value;
  source_t                   pend_src;
  source_t                   next_pend_src;
  logic                      pend_under;
  logic                      next_pend_under;
  logic                      pend_over;
  logic                      next_pend_over;
  logic                      pend_valid;
  logic                      next_pend_valid;
  logic                      next_rate_blocked;
  logic                      take;

  // captured working set
  scale_state_e        state;
  scale_state_e        next_state;
  logic [VALUE_W-1:0]  cap_mag;
  logic [VALUE_W-1:0]  next_cap_mag;
  logic [VALUE_W-1:0]  cap_max;
  logic [VALUE_W-1:0]  next_cap_max;
  logic [CODE_W-1:0]   cap_zero;
  logic [CODE_W-1:0]   next_cap_zero;
  logic [CODE_W-1:0]   cap_delta;
  logic [CODE_W-1:0]   next_cap_delta;
  logic                cap_neg;
  logic                next_cap_neg;
  logic                cap_rate;
  logic                next_cap_rate;
  logic                cap_abs_rate;
  logic                next_cap_abs_rate;
  logic                cap_under;
  logic                next_cap_under;
  logic                cap_over;
  logic                next_cap_over;
  logic                cap_mode;
  logic                next_cap_mode;
  logic [CODE_W-1:0]   next_dac_code;
  logic                next_dac_load;
  logic                next_under_clamp;
  logic                next_over_clamp;

  // scaling arithmetic
  logic                div_start;
  logic                div_done;
  logic [PROD_W-1:0]   product;
  logic [PROD_W-1:0]   quot;
  logic                under_range;
  logic                over_range;
  logic                under_hit;
  logic                over_hit;
  logic [CODE_W-1:0]   lin_code;
  logic [CODE_W-1:0]   final_code;

  always_comb begin
    sel_value = displayed_weight;
    sel_valid = 1'b0;
    sel_legal = 1'b1;
    case (source_select) // see R1
      SRC_DISPLAYED, SRC_ABS_DISPLAYED: begin
        sel_value = displayed_weight;
        sel_valid = displayed_valid;
      end
      SRC_GROSS: begin
        sel_value = gross_weight;
        sel_valid = gross_valid;
      end
      SRC_RATE, SRC_ABS_RATE: begin
        sel_value = rate_value;
        sel_valid = rate_valid;
      end
      default: begin
        sel_legal = 1'b0;
      end
    endcase
  end

  assign accept = sel_valid && sel_legal && (!is_rate_src(source_select) || rate_enable); // see R9
  assign take = pend_valid && (state == ST_IDLE);

  always_comb begin
    next_pend_value = pend_value;
    next_pend_src = pend_src;
    next_pend_under = pend_under;
    next_pend_over = pend_over;
    next_pend_valid = pend_valid;
    next_rate_blocked = is_rate_src(source_select) && !rate_enable; // see R9
    // a new sample wins over the slot being emptied in the same cycle
    if (accept) begin // see R14
      next_pend_value = sel_value;
      next_pend_src = source_select;
      next_pend_under = blank_under;
      next_pend_over = blank_over;
      next_pend_valid = 1'b1;
    end else if (take) begin
      next_pend_valid = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pend_value <= '0;
      pend_src <= SRC_DISPLAYED;
      pend_under <= 1'b0;
      pend_over <= 1'b0;
      pend_valid <= 1'b0;
      rate_blocked <= 1'b0;
    end else begin
      pend_value <= next_pend_value;
      pend_src <= next_pend_src;
      pend_under <= next_pend_under;
      pend_over <= next_pend_over;
      pend_valid <= next_pend_valid;
      rate_blocked <= next_rate_blocked;
    end
  end

  assign product = PROD_W'(cap_mag) * PROD_W'(cap_delta); // see R6
  assign div_start = (state == ST_START);

  scale_divider u_div (
    .clock    (clock),
    .reset_n  (reset_n),
    .start    (div_start),
    .dividend (product),
    .divisor  (cap_max),
    .done     (div_done),
    .quotient (quot)
  );

  always_comb begin
    // under/over decisions depend on the source only; the mode just picks the clamp code; see R10
    under_range = cap_neg && (quot > PROD_W'(cap_zero));
    over_range = (!cap_neg && (quot > PROD_W'(CODE_FULL - cap_zero))) // see R15
      || (cap_rate && (cap_mag > cap_max))
      || ((cap_max == '0) && (cap_mag != '0));
    under_hit = cap_under || under_range || (cap_neg && cap_rate);
    over_hit = !under_hit && (cap_over || over_range);
    lin_code = cap_neg ? CODE_W'(cap_zero - quot[CODE_W-1:0])
                       : CODE_W'(cap_zero + quot[CODE_W-1:0]); // see R4
    if (under_hit) begin
      final_code = (cap_mode == MODE_CURRENT) ? CODE_0MA : CODE_V_FLOOR; // see R11
    end else if (over_hit) begin
      final_code = (cap_mode == MODE_CURRENT) ? CODE_24MA : CODE_FULL; // see R12
    end else begin
      final_code = lin_code; // see R5
    end
  end

  always_comb begin
    next_state = state;
    next_cap_mag = cap_mag;
    next_cap_max = cap_max;
    next_cap_zero = cap_zero;
    next_cap_delta = cap_delta;
    next_cap_neg = cap_neg;
    next_cap_rate = cap_rate;
    next_cap_abs_rate = cap_abs_rate;
    next_cap_under = cap_under;
    next_cap_over = cap_over;
    next_cap_mode = cap_mode;
    next_dac_code = dac_code;
    next_dac_load = 1'b0;
    next_under_clamp = under_clamp;
    next_over_clamp = over_clamp;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_cap_mag = magnitude(pend_value); // see R7
          next_cap_neg = pend_value[VALUE_W-1]
            && (pend_src != SRC_ABS_DISPLAYED) && (pend_src != SRC_ABS_RATE);
          next_cap_rate = is_rate_src(pend_src);
          next_cap_abs_rate = (pend_src == SRC_ABS_RATE);
          // rate sources have no display blanking; absolute rate never goes under
          next_cap_under = pend_under && !is_rate_src(pend_src); // see R13
          next_cap_over = pend_over && !is_rate_src(pend_src);
          next_cap_max = span_max;
          next_cap_zero = zero_cal; // see R8
          // an inverted calibration collapses to a flat output rather than wrapping
          next_cap_delta = (high_cal >= zero_cal) ? CODE_W'(high_cal - zero_cal) : '0;
          next_cap_mode = output_mode; // see R3
          next_state = ST_START;
        end
      end
      ST_START: begin
        next_state = ST_DIVIDE;
      end
      ST_DIVIDE: begin
        if (div_done) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        next_dac_code = final_code; // see R2
        next_dac_load = 1'b1; // see R14
        next_under_clamp = under_hit;
        next_over_clamp = over_hit;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      cap_mag <= '0;
      cap_max <= '0;
      cap_zero <= CODE_RESET;
      cap_delta <= '0;
      cap_neg <= 1'b0;
      cap_rate <= 1'b0;
      cap_abs_rate <= 1'b0;
      cap_under <= 1'b0;
      cap_over <= 1'b0;
      cap_mode <= MODE_CURRENT;
      dac_code <= CODE_RESET;
      dac_load <= 1'b0;
      under_clamp <= 1'b0;
      over_clamp <= 1'b0;
    end else begin
      state <= next_state;
      cap_mag <= next_cap_mag;
      cap_max <= next_cap_max;
      cap_zero <= next_cap_zero;
      cap_delta <= next_cap_delta;
      cap_neg <= next_cap_neg;
      cap_rate <= next_cap_rate;
      cap_abs_rate <= next_cap_abs_rate;
      cap_under <= next_cap_under;
      cap_over <= next_cap_over;
      cap_mode <= next_cap_mode;
      dac_code <= next_dac_code;
      dac_load <= next_dac_load;
      under_clamp <= next_under_clamp;
      over_clamp <= next_over_clamp;
    end
  end

  assign busy = (state != ST_IDLE);

  load_pulse_a: assert property (@(posedge clock) disable iff (!reset_n) // see R14
    dac_load |=> !dac_load)
    else $error("load strobe longer than one cycle");

  code_hold_a: assert property (@(posedge clock) disable iff (!reset_n) // see R14
    !dac_load |-> $stable(dac_code))
    else $error("converter code changed without a load");

  div_bound_a: assert property (@(posedge clock) disable iff (!reset_n) // see R14
    (state == ST_START) |-> ##[49:51] (state == ST_LOAD))
    else $error("scaling did not finish in time");

  under_current_a: assert property (@(posedge clock) disable iff (!reset_n) // see R11
    (dac_load && under_clamp && cap_mode == MODE_CURRENT) |-> (dac_code == CODE_0MA))
    else $error("under-zero clamp did not drive the 0 mA code");

  over_current_a: assert property (@(posedge clock) disable iff (!reset_n) // see R12
    (dac_load && over_clamp && cap_mode == MODE_CURRENT) |-> (dac_code == CODE_24MA))
    else $error("over-limit clamp did not drive the 24 mA code");

  abs_rate_a: assert property (@(posedge clock) disable iff (!reset_n) // see R13
    (dac_load && cap_abs_rate) |-> !under_clamp)
    else $error("absolute rate hit the under-zero clamp");

  rate_gate_a: assert property (@(posedge clock) disable iff (!reset_n) // see R9
    (sel_valid && is_rate_src(source_select) && !rate_enable && !pend_valid)
      |=> !pend_valid)
    else $error("rate sample taken while rate is disabled");

  zero_point_a: assert property (@(posedge clock) disable iff (!reset_n) // see R4
    (dac_load && !under_clamp && !over_clamp && cap_mag == '0) |-> (dac_code == cap_zero))
    else $error("zero value did not give the zero calibration code");

  full_scale_a: assert property (@(posedge clock) disable iff (!reset_n) // see R5
    (dac_load && !under_clamp && !over_clamp && !cap_neg && cap_mag == cap_max
      && cap_max != '0) |-> (dac_code == CODE_W'(cap_zero + cap_delta)))
    else $error("maximum value did not give the high calibration code");

endmodule : analog_output_scaler
`default_nettype wire

//--- src/scale_divider.sv
// restoring divider for the scaling quotient, one quotient bit per cycle
`timescale 1ns/10ps
`default_nettype none
module scale_divider
  import analog_output_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                reset_n,
  input  wire logic                start,
  input  wire logic [PROD_W-1:0]   dividend,
  input  wire logic [VALUE_W-1:0]  divisor,
  output logic                     done,
  output logic      [PROD_W-1:0]   quotient
);
  import analog_output_pkg::*;

  logic [VALUE_W-1:0] rem;
  logic [VALUE_W-1:0] next_rem;
  logic [PROD_W-1:0]  next_quotient;
  logic [5:0]         count;
  logic [5:0]         next_count;
  logic               busy;
  logic               next_busy;
  logic               next_done;
  logic [VALUE_W:0]   trial;

  always_comb begin
    next_rem = rem;
    next_quotient = quotient;
    next_count = count;
    next_busy = busy;
    next_done = 1'b0;
    trial = {rem, quotient[PROD_W-1]};
    if (start) begin
      next_rem = '0;
      next_quotient = dividend;
      next_count = DIV_STEPS;
      next_busy = 1'b1;
    end else if (busy) begin
      // divisor of zero yields all ones; the caller treats it as overrange
      if (trial >= {1'b0, divisor}) begin
        next_rem = VALUE_W'(trial - {1'b0, divisor});
        next_quotient = {quotient[PROD_W-2:0], 1'b1};
      end else begin
        next_rem = trial[VALUE_W-1:0];
        next_quotient = {quotient[PROD_W-2:0], 1'b0};
      end
      next_count = count - DIV_LAST;
      if (count == DIV_LAST) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rem <= '0;
      quotient <= '0;
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      rem <= next_rem;
      quotient <= next_quotient;
      count <= next_count;
      busy <= next_busy;
      done <= next_done;
    end
  end

endmodule : scale_divider
`default_nettype wire
